// ===== tb_tmctl_timer.sv
// self-checking bench for the timer block
`timescale 1ns/100ps
`include "tmctl_params.svh"
module tb_tmctl_timer;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`TMCTL_ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rv;
  logic pready, pslverr, ext_count_clock_pin, crystal_in_pin, cap_sense_oscillator, er;
  logic crystal_out_pin, crystal_out_oe, low_power_osc_enable, counter_on;
  logic gate_active, count_tick;
  logic [15:0] count_value, c0;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int n_ticks = 0;
  int t0;
  // control byte, then expected counts in 64 cycles
  logic [15:0] cases [10] = '{16'h0510, 16'h3502, 16'h4140, 16'h5120, 16'h6510,
    16'h7108, 16'h8108, 16'h8508, 16'h9D10, 16'hC110};
  // crystal node is pulled low while undriven
  assign crystal_in_pin = crystal_out_oe ? crystal_out_pin : 1'b0;
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  tmctl_ext_osc #(.HALF(4)) ext_src (.pclk, .presetn, .wave(ext_count_clock_pin));
  tmctl_ext_osc #(.HALF(2)) cap_src (.pclk, .presetn, .wave(cap_sense_oscillator));
  tmctl_timer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ext_count_clock_pin, .crystal_in_pin, .cap_sense_oscillator,
    .crystal_out_pin, .crystal_out_oe, .low_power_osc_enable, .counter_on,
    .gate_active, .count_value, .count_tick);
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // request stands until the edge at which pready is sampled high
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  always @(posedge pclk) begin
    cyc++;
    if (count_tick === 1'b1) begin
      n_ticks++;
    end
    if (cyc == 5000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, 12'h040, 32'h0);
    chk("ctrl reset", rv, 32'h0);
    xfer(1'b0, 12'h044, 32'h0);
    chk("unmapped err", {31'h0, er}, 32'h1);
    $display("reset test ended");
    xfer(1'b1, 12'h040, 32'hFF);
    xfer(1'b0, 12'h040, 32'h0);
    chk("ctrl read", rv, 32'hFD);
    chk("osc drive", {31'h0, crystal_out_oe}, 32'h1);
    xfer(1'b1, 12'h040, 32'h0);
    repeat (2) @(posedge pclk);
    #1;
    chk("gate", {31'h0, gate_active}, 32'h0);
    $display("control test ended");
    xfer(1'b1, 12'h038, 32'hFC);
    xfer(1'b1, 12'h03C, 32'hFF);
    xfer(1'b1, 12'h040, 32'h41);
    repeat (8) @(posedge pclk);
    xfer(1'b1, 12'h040, 32'h0);
    xfer(1'b0, 12'h03C, 32'h0);
    chk("wrap high", rv, 32'h0);
    xfer(1'b0, 12'h038, 32'h0);
    chk("wrap low", rv, 32'h7);
    $display("wrap test ended");
    foreach (cases[i]) begin
      xfer(1'b1, 12'h040, {24'h0, cases[i][15:8]});
      repeat (16) @(posedge pclk);
      #1;
      c0 = count_value;
      t0 = n_ticks;
      repeat (64) @(posedge pclk);
      #1;
      chk("rate", {16'h0, count_value - c0}, {24'h0, cases[i][7:0]});
      chk("tick", n_ticks - t0, {24'h0, cases[i][7:0]});
    end
    $display("rate test ended");
    wrap_up();
  end
endmodule : tb_tmctl_timer

// ===== tmctl_edge_sync.sv
// rising-edge detector with optional two-stage synchronizer
`timescale 1ns/100ps
`include "tmctl_params.svh"
module tmctl_edge_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic raw_in,
  input wire logic bypass_sync,
  output logic rise
);
  logic sync_1;
  logic sync_2;
  logic sync_3;
  logic raw_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_1 <= 1'b0;
      sync_2 <= 1'b0;
      sync_3 <= 1'b0;
      raw_d <= 1'b0;
    end else begin
      sync_1 <= raw_in;
      sync_2 <= sync_1;
      sync_3 <= sync_2;
      raw_d <= raw_in;
    end
  end

  assign rise = bypass_sync ? (raw_in & ~raw_d) : (sync_2 & ~sync_3);
endmodule : tmctl_edge_sync

// ===== tmctl_ext_osc.sv
// free-running square wave standing in for an outside clock source
`timescale 1ns/100ps
module tmctl_ext_osc #(
  parameter int HALF = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic wave
);
  int cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      wave <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      wave <= ~wave;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : tmctl_ext_osc

// ===== tmctl_params.svh
// constants for the sixteen-bit timer control block
// Summary of operation
// - control fields at bits 7-6,5-4,3,2,0
// - source 11 counts capacitive sensing oscillator
// - source 10, oscillator off: pin rising edges
// - source 10, oscillator on: crystal input pin edges
// - source 01 counts every system clock
// - source 00 counts instruction clock, quarter rate
// - prescale 00/01/10/11 divides 1/2/4/8
// - oscillator enable bit turns crystal driver on
// - external source, sync bit 0: synchronized
// - external source, sync bit 1: unsynchronized
// - internal sources ignore the sync bit
// - on bit enables counting per prescaled tick
// - clearing on stops and clears gate
// - control bit 1 ignores writes, reads zero
`ifndef TMCTL_PARAMS_SVH
`define TMCTL_PARAMS_SVH

`define TMCTL_ADDR_W 12
`define TMCTL_IDX_COUNT_LOW 10'h00E
`define TMCTL_IDX_COUNT_HIGH 10'h00F
`define TMCTL_IDX_CONTROL 10'h010

`define TMCTL_BIT_SRC_HI 7
`define TMCTL_BIT_SRC_LO 6
`define TMCTL_BIT_PS_HI 5
`define TMCTL_BIT_PS_LO 4
`define TMCTL_BIT_OSC_EN 3
`define TMCTL_BIT_SYNC_N 2
`define TMCTL_BIT_ON 0

`define TMCTL_SRC_INSTR 2'h0
`define TMCTL_SRC_SYSTEM 2'h1
`define TMCTL_SRC_EXTERNAL 2'h2
`define TMCTL_SRC_CAP 2'h3

`define TMCTL_CTRL_RESET 8'h00
`define TMCTL_COUNT_RESET 16'h0000
`define TMCTL_COUNT_ONE 16'h0001
`define TMCTL_INSTR_DIV_LAST 2'h3
`define TMCTL_INSTR_DIV_STEP 2'h1
`define TMCTL_PS_RESET 3'h0
`define TMCTL_PS_STEP 3'h1
`define TMCTL_PS_LIMIT_1 3'h0
`define TMCTL_PS_LIMIT_2 3'h1
`define TMCTL_PS_LIMIT_4 3'h3
`define TMCTL_PS_LIMIT_8 3'h7
`define TMCTL_WORD_ZERO 32'h00000000

`endif

// ===== tmctl_pkg.sv
// types shared by the timer control block
package tmctl_pkg;

  typedef struct packed {
    logic [1:0] src_sel;
    logic [1:0] prescale_sel;
    logic osc_en;
    logic sync_n;
    logic spare;
    logic on;
  } tmctl_ctrl_t;

  typedef enum logic [1:0] {
    TMCTL_ST_IDLE = 2'b01,
    TMCTL_ST_ANSWER = 2'b10
  } tmctl_bus_state_t;

endpackage : tmctl_pkg

// ===== tmctl_prescaler.sv
// divides the selected count tick by 1, 2, 4 or 8
`timescale 1ns/100ps
`include "tmctl_params.svh"
module tmctl_prescaler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic tick_in,
  input wire logic [1:0] sel,
  output logic tick_out
);
  logic [2:0] cnt;
  logic [2:0] limit;

  always_comb begin
    case (sel)
      2'h0: limit = `TMCTL_PS_LIMIT_1;
      2'h1: limit = `TMCTL_PS_LIMIT_2;
      2'h2: limit = `TMCTL_PS_LIMIT_4;
      default: limit = `TMCTL_PS_LIMIT_8;
    endcase
  end

  assign tick_out = tick_in & (cnt >= limit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= `TMCTL_PS_RESET;
    end else if (clear) begin
      cnt <= `TMCTL_PS_RESET;
    end else if (tick_out) begin
      cnt <= `TMCTL_PS_RESET;
    end else if (tick_in) begin
      cnt <= cnt + `TMCTL_PS_STEP;
    end
  end
endmodule : tmctl_prescaler

// ===== tmctl_timer.sv
// sixteen-bit timer with selectable source, prescaler and apb registers
//
// Design decision made here: register access over APB.
`timescale 1ns/100ps
`include "tmctl_params.svh"
module tmctl_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TMCTL_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_count_clock_pin,
  input wire logic crystal_in_pin,
  input wire logic cap_sense_oscillator,
  output logic crystal_out_pin,
  output logic crystal_out_oe,
  output logic low_power_osc_enable,
  output logic counter_on,
  output logic gate_active,
  output logic [15:0] count_value,
  output logic count_tick
);
  tmctl_pkg::tmctl_ctrl_t ctrl;
  tmctl_pkg::tmctl_bus_state_t bus_state;
  tmctl_pkg::tmctl_bus_state_t next_bus_state;
  logic [15:0] count;
  logic gate_ff;
  logic [1:0] instr_div;
  logic instr_tick;
  logic cap_d;
  logic cap_rise;
  logic ext_raw;
  logic ext_rise;
  logic src_tick;
  logic ps_tick;
  logic hit_low;
  logic hit_high;
  logic hit_ctrl;
  logic mapped;
  logic wr_take;
  logic [31:0] rd_word;

  // address decode: word index times four
  assign hit_low = (paddr[1:0] == 2'h0) && (paddr[`TMCTL_ADDR_W-1:2] == `TMCTL_IDX_COUNT_LOW);
  assign hit_high = (paddr[1:0] == 2'h0) && (paddr[`TMCTL_ADDR_W-1:2] == `TMCTL_IDX_COUNT_HIGH);
  assign hit_ctrl = (paddr[1:0] == 2'h0) && (paddr[`TMCTL_ADDR_W-1:2] == `TMCTL_IDX_CONTROL);
  assign mapped = hit_low | hit_high | hit_ctrl;

  // write lands on the edge where pready is sampled high
  assign wr_take = psel & penable & pready & pwrite & mapped;

  // bus answer state machine: one wait cycle, then pready
  always_comb begin
    next_bus_state = bus_state;
    case (bus_state)
      tmctl_pkg::TMCTL_ST_IDLE: begin
        if (psel && penable) begin
          next_bus_state = tmctl_pkg::TMCTL_ST_ANSWER;
        end
      end
      tmctl_pkg::TMCTL_ST_ANSWER: begin
        next_bus_state = tmctl_pkg::TMCTL_ST_IDLE;
      end
      default: begin
        next_bus_state = tmctl_pkg::TMCTL_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_state <= tmctl_pkg::TMCTL_ST_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  // read word assembly
  always_comb begin
    rd_word = `TMCTL_WORD_ZERO;
    if (hit_low) begin
      rd_word[7:0] = count[7:0];
    end else if (hit_high) begin
      rd_word[7:0] = count[15:8];
    end else if (hit_ctrl) begin
      rd_word[`TMCTL_BIT_SRC_HI:`TMCTL_BIT_SRC_LO] = ctrl.src_sel;
      rd_word[`TMCTL_BIT_PS_HI:`TMCTL_BIT_PS_LO] = ctrl.prescale_sel;
      rd_word[`TMCTL_BIT_OSC_EN] = ctrl.osc_en;
      rd_word[`TMCTL_BIT_SYNC_N] = ctrl.sync_n;
      rd_word[`TMCTL_BIT_ON] = ctrl.on;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `TMCTL_WORD_ZERO;
    end else if (bus_state == tmctl_pkg::TMCTL_ST_IDLE && psel && penable) begin
      pready <= 1'b1;
      pslverr <= ~mapped;
      prdata <= pwrite ? `TMCTL_WORD_ZERO : rd_word;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `TMCTL_WORD_ZERO;
    end
  end

  // control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `TMCTL_CTRL_RESET;
    end else if (wr_take && hit_ctrl) begin
      ctrl.src_sel <= pwdata[`TMCTL_BIT_SRC_HI:`TMCTL_BIT_SRC_LO];
      ctrl.prescale_sel <= pwdata[`TMCTL_BIT_PS_HI:`TMCTL_BIT_PS_LO];
      ctrl.osc_en <= pwdata[`TMCTL_BIT_OSC_EN];
      ctrl.sync_n <= pwdata[`TMCTL_BIT_SYNC_N];
      ctrl.spare <= 1'b0;
      ctrl.on <= pwdata[`TMCTL_BIT_ON];
    end
  end

  // instruction clock at a quarter of pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_div <= 2'h0;
    end else begin
      instr_div <= instr_div + `TMCTL_INSTR_DIV_STEP;
    end
  end
  assign instr_tick = (instr_div == `TMCTL_INSTR_DIV_LAST);

  // capacitive oscillator rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_d <= 1'b0;
    end else begin
      cap_d <= cap_sense_oscillator;
    end
  end
  assign cap_rise = cap_sense_oscillator & ~cap_d;

  assign ext_raw = ctrl.osc_en ? crystal_in_pin : ext_count_clock_pin;

  tmctl_edge_sync u_ext_edge (
    .pclk(pclk),
    .presetn(presetn),
    .raw_in(ext_raw),
    .bypass_sync(ctrl.sync_n),
    .rise(ext_rise)
  );

  // source selection; sync bit only reaches the external path
  always_comb begin
    case (ctrl.src_sel)
      `TMCTL_SRC_INSTR: src_tick = instr_tick;
      `TMCTL_SRC_SYSTEM: src_tick = 1'b1;
      `TMCTL_SRC_EXTERNAL: src_tick = ext_rise;
      `TMCTL_SRC_CAP: src_tick = cap_rise;
      default: src_tick = 1'b0;
    endcase
  end

  tmctl_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .clear(~ctrl.on),
    .tick_in(src_tick),
    .sel(ctrl.prescale_sel),
    .tick_out(ps_tick)
  );

  // gate flip-flop follows the on bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_ff <= 1'b0;
    end else begin
      gate_ff <= ctrl.on;
    end
  end

  // count register; a software byte write wins over the increment
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= `TMCTL_COUNT_RESET;
    end else if (wr_take && hit_low) begin
      count[7:0] <= pwdata[7:0];
    end else if (wr_take && hit_high) begin
      count[15:8] <= pwdata[7:0];
    end else if (ctrl.on && gate_ff && ps_tick) begin
      count <= count + `TMCTL_COUNT_ONE;
    end
  end

  // registered status and oscillator outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_tick <= 1'b0;
      crystal_out_pin <= 1'b0;
      crystal_out_oe <= 1'b0;
    end else begin
      count_tick <= ctrl.on & gate_ff & ps_tick;
      crystal_out_pin <= ctrl.osc_en & ~crystal_in_pin;
      crystal_out_oe <= ctrl.osc_en;
    end
  end

  assign low_power_osc_enable = ctrl.osc_en;
  assign counter_on = ctrl.on;
  assign gate_active = gate_ff;
  assign count_value = count;
endmodule : tmctl_timer

// ===== tmctl_timer_monitor.sv
// assertion checker for the timer block ports
`timescale 1ns/100ps
`include "tmctl_params.svh"
module tmctl_timer_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TMCTL_ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic crystal_out_pin,
  input wire logic crystal_out_oe,
  input wire logic low_power_osc_enable,
  input wire logic counter_on,
  input wire logic gate_active,
  input wire logic [15:0] count_value
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_bump;
    $changed(count_value) && !$past(pready);
  endsequence
  a_ready_wait: assert property (s_setup |=> pready)
    else $error("ready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready too long");
  a_unmapped_err: assert property (pready && !(paddr inside {12'h038, 12'h03C, 12'h040})
    |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
  a_ctrl_spare: assert property (pready && !pwrite && paddr == 12'h040
    |-> prdata[31:8] == 24'h0 && !prdata[1]) else $error("spare bit set");
  a_gate_clear: assert property (!counter_on |=> !gate_active)
    else $error("gate kept");
  a_count_step: assert property (s_bump |-> count_value == $past(count_value) + 16'h1)
    else $error("count jump");
  a_count_on: assert property (s_bump |-> $past(counter_on))
    else $error("count while off");
  a_osc_follow: assert property ($changed(low_power_osc_enable)
    |=> crystal_out_oe == $past(low_power_osc_enable)) else $error("osc drive wrong");
  a_osc_quiet: assert property (!crystal_out_oe |-> !crystal_out_pin)
    else $error("osc pin driven");
endmodule : tmctl_timer_monitor
bind tmctl_timer tmctl_timer_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .crystal_out_pin, .crystal_out_oe,
  .low_power_osc_enable, .counter_on, .gate_active, .count_value);
